/* rtl/lsl_loader.sv */
// Serial load port: shifts a host bit stream in and commits it by stream length.
// Assumes serial clock, data and select arrive asynchronously and are far slower than core_clk.
`timescale 1ns/1ps
`default_nettype none
module lsl_loader (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic port_select_n,
  output logic serial_out,
  output logic serial_out_en,
  output logic [7:0] configuration_word,
  output logic [15:0] feedback_divider_word,
  output logic [14:0] reference_divider_word,
  output logic feedback_load,
  output logic device_reinit
);
  typedef struct packed {
    lsl_pkg::lsl_state_type state;
    logic [lsl_pkg::SHIFT_W-1:0] shift;
    logic half_stage;
    logic [lsl_pkg::CNT_W-1:0] count;
    logic overflow;
    logic clk_prev;
    logic sel_prev;
    logic reset_armed;
    logic [7:0] cfg;
    logic [15:0] fbd;
    logic [14:0] refd;
    logic fbd_load;
    logic reinit;
    logic out_en;
  } lsl_state_vec_type;

  // Where a released frame goes, decided by its length and, for a five-clock frame, by the arm left by a four-clock frame
  typedef enum logic [2:0] {
    LSL_TO_NONE = 3'h0,
    LSL_TO_CFG = 3'h1,
    LSL_TO_FBD = 3'h2,
    LSL_TO_REF = 3'h3,
    LSL_TO_ARM = 3'h4,
    LSL_TO_INIT = 3'h5
  } lsl_dest_type;

  lsl_state_vec_type st;
  lsl_state_vec_type next_st;
  logic [1:0] rst_sync;
  logic rst_n;
  // Filtered pin levels
  logic clk_s;
  logic din_s;
  logic sel_n_s;
  // Edges seen on the filtered levels
  logic clk_rise;
  logic clk_fall;
  logic sel_fall;
  logic sel_rise;
  // Destination of the frame now held in the shift path
  lsl_dest_type commit_dest;

  // True when a count is exactly the given value
  function automatic logic lsl_count_is(input logic [5:0] cnt, input logic [5:0] want);
    lsl_count_is = (cnt == want);
  endfunction

  // True on a low to high step between two samples
  function automatic logic lsl_rose(input logic now, input logic prev);
    lsl_rose = now && !prev;
  endfunction

  // True on a high to low step between two samples
  function automatic logic lsl_fell(input logic now, input logic prev);
    lsl_fell = !now && prev;
  endfunction

  // Next clock count; it stops at the top so that long frames stay refused
  function automatic logic [5:0] lsl_count_step(input logic [5:0] cnt);
    if (cnt == lsl_pkg::CNT_MAX) begin
      lsl_count_step = cnt;
    end else begin
      lsl_count_step = cnt + 6'h01;
    end
  endfunction

  // Move one bit into the bottom of the shift path
  function automatic logic [15:0] lsl_shift_in(input logic [15:0] sh, input logic bit_in);
    lsl_shift_in = {sh[lsl_pkg::SHIFT_W-2:0], bit_in};
  endfunction

  // Configuration slice; bit zero is always the last bit shifted in
  function automatic logic [7:0] lsl_cfg_of(input logic [15:0] sh);
    lsl_cfg_of = sh[lsl_pkg::CFG_W-1:0];
  endfunction

  // Feedback divider slice, the whole shift path
  function automatic logic [15:0] lsl_fbd_of(input logic [15:0] sh);
    lsl_fbd_of = sh[lsl_pkg::FBD_W-1:0];
  endfunction

  // Reference slice; a long frame drops its leading bits here
  function automatic logic [14:0] lsl_ref_of(input logic [15:0] sh);
    lsl_ref_of = sh[lsl_pkg::REFD_W-1:0];
  endfunction

  // Map a clock count to its destination; a frame past the top goes nowhere
  function automatic lsl_dest_type lsl_dest_of(
    input logic [5:0] cnt,
    input logic ovf,
    input logic armed
  );
    lsl_dest_type dest;
    dest = LSL_TO_NONE;
    if (ovf) begin
      dest = LSL_TO_NONE;
    end else if (lsl_count_is(cnt, lsl_pkg::CNT_CFG)) begin
      dest = LSL_TO_CFG;
    end else if (lsl_count_is(cnt, lsl_pkg::CNT_FBD)) begin
      dest = LSL_TO_FBD;
    end else if (lsl_count_is(cnt, lsl_pkg::CNT_REF_SHORT)) begin
      dest = LSL_TO_REF;
    end else if (lsl_count_is(cnt, lsl_pkg::CNT_REF_LONG)) begin
      dest = LSL_TO_REF;
    end else if (lsl_count_is(cnt, lsl_pkg::CNT_RST_FIRST)) begin
      dest = LSL_TO_ARM;
    end else if (lsl_count_is(cnt, lsl_pkg::CNT_RST_SECOND) && armed) begin
      dest = LSL_TO_INIT;
    end else begin
      dest = LSL_TO_NONE;
    end
    lsl_dest_of = dest;
  endfunction

  // Reset release through two flip-flops
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  // Pin synchronisers: serial clock pin
  lsl_sync u_sync_clk (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_in(serial_clk),
    .level(clk_s)
  );
  // Serial data pin
  lsl_sync u_sync_din (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_in(serial_in),
    .level(din_s)
  );
  // Select pin
  lsl_sync u_sync_sel (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_in(port_select_n),
    .level(sel_n_s)
  );

  // Serial clock edges on the filtered level
  assign clk_rise = lsl_rose(clk_s, st.clk_prev);
  assign clk_fall = lsl_fell(clk_s, st.clk_prev);

  // Select edges; the previous sample resets low like the filter, so no false frame opens after reset
  assign sel_fall = lsl_fell(sel_n_s, st.sel_prev);
  assign sel_rise = lsl_rose(sel_n_s, st.sel_prev);

  // Destination picked from the length shifted so far
  assign commit_dest = lsl_dest_of(st.count, st.overflow, st.reset_armed);

  // Port sequencing, shifting and commit
  always_comb begin
    next_st = st;
    next_st.clk_prev = clk_s;
    next_st.sel_prev = sel_n_s;
    next_st.fbd_load = 1'b0;
    next_st.reinit = 1'b0;
    case (st.state)
      lsl_pkg::LSL_IDLE: begin
        // Held initialised while deselected; resync needs clock low
        next_st.count = '0;
        next_st.overflow = 1'b0;
        next_st.shift = '0;
        next_st.half_stage = 1'b0;
        next_st.out_en = 1'b0;
        if (sel_fall) begin
          // Select dropped with the clock high leaves the port out of step
          if (clk_s) begin
            next_st.state = lsl_pkg::LSL_LOST;
          end else begin
            next_st.state = lsl_pkg::LSL_SHIFT;
            next_st.out_en = 1'b1;
          end
        end
      end
      lsl_pkg::LSL_SHIFT: begin
        // Every bit is data, shifted in MSB first on rising clock
        if (clk_rise) begin
          next_st.shift = lsl_shift_in(st.shift, din_s);
          // Count each rising clock; past the top the frame is refused
          if (st.count == lsl_pkg::CNT_MAX) begin
            next_st.overflow = 1'b1;
          end
          next_st.count = lsl_count_step(st.count);
        end
        // Half stage presents the top bit on the falling clock
        if (clk_fall) begin
          next_st.half_stage = st.shift[lsl_pkg::SHIFT_W-1];
        end
        if (sel_rise) begin
          // Commit only at release, chosen by length and the reset arm
          next_st.state = lsl_pkg::LSL_IDLE;
          next_st.out_en = 1'b0;
          next_st.reset_armed = 1'b0;
          case (commit_dest)
            LSL_TO_CFG: begin
              next_st.cfg = lsl_cfg_of(st.shift);
            end
            LSL_TO_FBD: begin
              next_st.fbd = lsl_fbd_of(st.shift);
              next_st.fbd_load = 1'b1;
            end
            LSL_TO_REF: begin
              next_st.refd = lsl_ref_of(st.shift);
            end
            LSL_TO_ARM: begin
              next_st.reset_armed = 1'b1;
            end
            LSL_TO_INIT: begin
              next_st.reinit = 1'b1;
              next_st.cfg = lsl_pkg::CFG_RESET;
              next_st.fbd = lsl_pkg::FBD_RESET;
              next_st.refd = lsl_pkg::REFD_RESET;
            end
            default: begin
              // Remaining counts load nothing
              next_st.reinit = 1'b0;
            end
          endcase
        end
      end
      lsl_pkg::LSL_LOST: begin
        // Out of step until select high and clock low
        next_st.out_en = 1'b0;
        if (sel_n_s && !clk_s) begin
          next_st.state = lsl_pkg::LSL_IDLE;
        end
      end
      default: begin
        // Unused code returns to idle
        next_st.state = lsl_pkg::LSL_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
      st.cfg <= lsl_pkg::CFG_RESET;
      st.fbd <= lsl_pkg::FBD_RESET;
      st.refd <= lsl_pkg::REFD_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state
  assign serial_out = st.half_stage;
  assign serial_out_en = st.out_en;
  assign configuration_word = st.cfg;
  assign feedback_divider_word = st.fbd;
  assign reference_divider_word = st.refd;
  assign feedback_load = st.fbd_load;
  assign device_reinit = st.reinit;
endmodule
`default_nettype wire

/* rtl/lsl_pkg.sv */
// Package of constants for the length selected serial loader.
// Assumes a single core clock domain; serial pins are sampled, not used as clocks.
package lsl_pkg;
  // Register widths
  localparam int unsigned CFG_W = 8;
  localparam int unsigned FBD_W = 16;
  localparam int unsigned REFD_W = 15;
  // Shift path holds the longest useful word; the half stage is a separate bit
  localparam int unsigned SHIFT_W = 16;
  localparam int unsigned CNT_W = 6;
  // Clock counts that pick a destination
  localparam logic [5:0] CNT_CFG = 6'h08;
  localparam logic [5:0] CNT_FBD = 6'h10;
  localparam logic [5:0] CNT_REF_SHORT = 6'h0f;
  localparam logic [5:0] CNT_REF_LONG = 6'h18;
  localparam logic [5:0] CNT_RST_FIRST = 6'h04;
  localparam logic [5:0] CNT_RST_SECOND = 6'h05;
  localparam logic [5:0] CNT_MAX = 6'h20;
  // Reset values of the port registers
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam logic [15:0] FBD_RESET = 16'h0000;
  localparam logic [14:0] REFD_RESET = 15'h0000;
  // Input synchroniser length
  localparam int unsigned SYNC_W = 3;
  // Port sequence states
  typedef enum logic [1:0] {
    LSL_IDLE = 2'b00,
    LSL_SHIFT = 2'b01,
    LSL_LOST = 2'b11
  } lsl_state_type;
endpackage

/* rtl/lsl_sync.sv */
// Three stage input synchroniser with an agreement filter.
// Assumes the input is asynchronous to core_clk.
`timescale 1ns/1ps
`default_nettype none
module lsl_sync (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pin_in,
  output logic level
);
  typedef struct packed {
    logic [lsl_pkg::SYNC_W-1:0] stage;
    logic level;
  } lsl_sync_state_type;
  lsl_sync_state_type st;
  lsl_sync_state_type next_st;

  // Shift the pin through; accept a change once the later two agree
  always_comb begin
    next_st = st;
    next_st.stage = {st.stage[lsl_pkg::SYNC_W-2:0], pin_in};
    if (st.stage[1] == st.stage[2]) begin
      next_st.level = st.stage[2];
    end
  end

  // Registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign level = st.level;
endmodule
`default_nettype wire

/* verification/lsl_host.sv */
// Host model driving the loader's serial port.
// Assumes the testbench calls send after reset.
`timescale 1ns/1ps
`default_nettype none
module lsl_host (
  input wire logic core_clk,
  input wire logic serial_out,
  input wire logic serial_out_en,
  output logic serial_clk,
  output logic serial_in,
  output logic port_select_n
);
  logic out_seen;
  logic en_seen;
  // Clock held at a rail from power up
  initial begin
    serial_clk = 1'b0;
    serial_in = 1'b0;
    port_select_n = 1'b1;
  end
  // Wait n core edges, then step past the edge
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // One framed transfer, select moved with the clock low
  task automatic send(input int n, input logic [31:0] d);
    port_select_n = 1'b0;
    hold(6);
    clock_out(n, d);
  endtask
  // Select dropped with the clock high; the port must ignore the frame
  task automatic send_lost(input int n, input logic [31:0] d);
    serial_clk = 1'b1;
    hold(6);
    port_select_n = 1'b0;
    hold(6);
    serial_clk = 1'b0;
    hold(6);
    clock_out(n, d);
  endtask
  // Clock n bits out MSB first, then release select with the clock low
  task automatic clock_out(input int n, input logic [31:0] d);
    for (int i = n - 1; i >= 0; i--) begin
      serial_in = d[i];
      hold(6);
      serial_clk = 1'b1;
      hold(6);
      serial_clk = 1'b0;
      hold(6);
    end
    out_seen = serial_out;
    en_seen = serial_out_en;
    port_select_n = 1'b1;
    serial_in = ~serial_in; // Released line shows no stale level
    hold(10);
  endtask
endmodule
`default_nettype wire

/* verification/lsl_checker_asserts.sv */
// Port checker for the loader.
// Assumes pins move at least five core cycles apart.
`timescale 1ns/1ps
`default_nettype none
module lsl_checker (
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic serial_clk,
  input wire logic serial_in,
  input wire logic port_select_n,
  input wire logic serial_out,
  input wire logic serial_out_en,
  input wire logic [7:0] configuration_word,
  input wire logic [15:0] feedback_divider_word,
  input wire logic [14:0] reference_divider_word,
  input wire logic feedback_load,
  input wire logic device_reinit
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Frame opened with the clock low
  sequence s_open;
    $fell(port_select_n) && !serial_clk ##1 (!port_select_n && !serial_clk) [*7];
  endsequence
  sequence s_idle;
    port_select_n [*8];
  endsequence
  AST_EN_FRAME: assert property (s_open |-> serial_out_en)
    else $error("output idle in frame");
  AST_FLOAT: assert property (s_idle |-> !serial_out_en)
    else $error("output driven while idle");
  AST_HOLD: assert property (!port_select_n [*8] |->
    $stable({configuration_word, feedback_divider_word, reference_divider_word}))
    else $error("word moved while selected");
  AST_CFG: assert property ($changed(configuration_word) |-> port_select_n)
    else $error("config commit while selected");
  AST_FBD: assert property (feedback_load |-> port_select_n ##1 !feedback_load)
    else $error("bad feedback pulse");
  AST_RST: assert property (device_reinit |-> port_select_n ##1 !device_reinit)
    else $error("bad reinit pulse");
  AST_OUT: assert property (serial_out_en && $past(serial_out_en) && $changed(serial_out) |-> !serial_clk)
    else $error("output moved on rise");
  AST_STATIC: assert property (($stable(serial_clk) && serial_out_en) [*8] |-> $stable(serial_out))
    else $error("output moved with clock still");
endmodule
`default_nettype wire

/* verification/testbench.sv */
// Testbench: host model frames each stream length.
// Assumes host model and checker compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic serial_clk, serial_in, port_select_n, serial_out, serial_out_en, feedback_load, device_reinit;
  logic [7:0] configuration_word;
  logic [15:0] feedback_divider_word;
  logic [14:0] reference_divider_word;
  int error_cnt = 0;
  int tests_run = 0;
  int loads = 0;
  int odd[6] = '{1, 7, 9, 17, 23, 32};
  always #25 core_clk = ~core_clk;
  lsl_host lsl_host_i (.core_clk, .serial_out, .serial_out_en, .serial_clk, .serial_in, .port_select_n);
  lsl_loader lsl_loader_i (.core_clk, .resetn, .serial_clk, .serial_in, .port_select_n, .serial_out,
    .serial_out_en, .configuration_word, .feedback_divider_word, .reference_divider_word,
    .feedback_load, .device_reinit);
  // Count one-cycle pulses of both kinds
  always @(posedge core_clk) begin
    loads <= loads + int'(feedback_load === 1'b1) + 256 * int'(device_reinit === 1'b1);
  end
  task automatic check(input string nm, input logic [38:0] e, input logic [38:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic words(input logic [38:0] e);
    check("words", e, {configuration_word, feedback_divider_word, reference_divider_word});
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge core_clk);
    #1 resetn = 1'b1;
    repeat (8) @(posedge core_clk);
    #1 check("idle_en", 39'h0, {38'h0, serial_out_en});
    lsl_host_i.send(8, 32'ha5);
    words({8'ha5, 16'h0, 15'h0});
    check("frame_en", 39'h1, {38'h0, lsl_host_i.en_seen});
    lsl_host_i.send(16, 32'hc3e1);
    words({8'ha5, 16'hc3e1, 15'h0});
    lsl_host_i.send(15, 32'h5a5a);
    words({8'ha5, 16'hc3e1, 15'h5a5a});
    lsl_host_i.send(24, 32'hffd2b4);
    words({8'ha5, 16'hc3e1, 15'h52b4});
    foreach (odd[i]) begin
      lsl_host_i.send(odd[i], 32'hffffffff);
      words({8'ha5, 16'hc3e1, 15'h52b4});
    end
    lsl_host_i.send(17, 32'h08000);
    check("wrap1", 39'h1, {38'h0, lsl_host_i.out_seen});
    lsl_host_i.send(17, 32'h17fff);
    check("wrap0", 39'h0, {38'h0, lsl_host_i.out_seen});
    lsl_host_i.send_lost(8, 32'h3c);
    words({8'ha5, 16'hc3e1, 15'h52b4});
    check("lost_en", 39'h0, {38'h0, lsl_host_i.en_seen});
    lsl_host_i.send(4, 32'h0);
    words({8'ha5, 16'hc3e1, 15'h52b4});
    lsl_host_i.send(5, 32'h0);
    words(39'h0);
    check("pulses", 39'h101, 39'(loads));
    tally_and_finish;
  end
  // Watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    tally_and_finish;
  end
endmodule
bind lsl_loader lsl_checker lsl_checker_i (.core_clk, .resetn, .serial_clk, .serial_in, .port_select_n,
  .serial_out, .serial_out_en, .configuration_word, .feedback_divider_word, .reference_divider_word,
  .feedback_load, .device_reinit);
`default_nettype wire
